//--- shared/srq_map.vh
// Purpose: constants for the status byte and service request block
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   included by the status design file only, by bare name
//
// How it works
// [RL1] request condition is summary AND enable bits
// [RL2] enable register written and read back by software
// [RL3] enabled summary rising sets bit 6, raises request
// [RL4] serial poll clears request-service aspect
// [RL5] no new request until event register cleared
// [RL6] master summary stays until enabled summaries clear
// [RL7] controller polls, finds device with bit 6
// [RL8] status query equals poll value, clears nothing
// [RL9] message-available bit follows output buffer nonempty
// [RL10] completion command sets event bit 0 later
// [RL11] completion query holds bus, then queues one
// [RL12] controller sends nothing during completion query
// [RL13] value 32 selects event summary and command error
// [RL14] event register query returns then clears register
// [RL15] summary bits follow sources, never latch
// [RL16] status byte bits: 7 op, 5 event, 4 message
// [RL17] event bits: 7 power, 5 cmd, 4 exe, 2 query, 0 done
`ifndef SRQ_MAP_VH
`define SRQ_MAP_VH

// register word addresses (byte address, aligned words)
`define SRQ_ADDR_W        8
`define SRQ_A_STB         8'h00
`define SRQ_A_SRE         8'h04
`define SRQ_A_ESR         8'h08
`define SRQ_A_ESE         8'h0C
`define SRQ_A_OPR         8'h10
`define SRQ_A_OPE         8'h14
`define SRQ_A_CMD         8'h18
`define SRQ_A_IST         8'h1C
`define SRQ_A_IMK         8'h20

// status byte bit positions
`define SRQ_SB_OSB        7
`define SRQ_SB_RQS        6
`define SRQ_SB_ESB        5
`define SRQ_SB_MAV        4

// standard event bit positions
`define SRQ_EV_PON        7
`define SRQ_EV_CME        5
`define SRQ_EV_EXE        4
`define SRQ_EV_QYE        2
`define SRQ_EV_OPC        0

// command register bits
`define SRQ_C_OPC         0
`define SRQ_C_OPCQ        1
`define SRQ_C_CLS         2

// interrupt status bits
`define SRQ_I_SRQ         0
`define SRQ_I_OPCQ        1
`define SRQ_I_POLL        2
`define SRQ_I_W           3

// reset values and constants
`define SRQ_BYTE_ZERO     8'h00
`define SRQ_INT_ZERO      3'h0
`define SRQ_WORD_ZERO     32'h0000_0000
`define SRQ_OPC_REPLY     8'h31
`define SRQ_SEL_ESB       8'h20

`endif

//--- verilog/srq_evreg.v
// Purpose: sticky event register with enable mask and summary bit
// Assumes: set and clear pulses come from logic on clk_in
// Notes:   a set in the same cycle as a clear wins
`default_nettype none

module srq_evreg #(
    parameter W = 8
) (
    // clock and reset
    input  wire         clk_in,
    input  wire         sys_rst_in,
    // event sources
    input  wire [W-1:0] set_in,
    input  wire         clr_in,
    // enable register write
    input  wire         en_wr_in,
    input  wire [W-1:0] en_data_in,
    // state
    output reg  [W-1:0] event_out,
    output reg  [W-1:0] enable_out,
    output wire         summary_out
);

    ////////////////////////////////////////////////////////////////////
    // sticky events: clear by query or clear-all, set wins
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            event_out <= {W{1'b0}};
        end else begin
            event_out <= (event_out & {W{~clr_in}}) | set_in; // [RL14]
        end
    end

    // enable register, loaded by software
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            enable_out <= {W{1'b0}};
        end else if (en_wr_in) begin
            enable_out <= en_data_in; // [RL13]
        end
    end

    // summary is combinational so it drops as soon as events clear
    assign summary_out = |(event_out & enable_out); // [RL15]

endmodule

`default_nettype wire

//--- verilog/srq_status.v
// Purpose: status byte, service request and operation complete logic
// Assumes: all inputs come from logic on clk_in; 25 MHz clock
// Notes:   registers sit on a plain strobe port, read data one cycle on
`include "srq_map.vh"
`default_nettype none

module srq_status (
    // clock and reset
    input  wire        clk_in,
    input  wire        sys_rst_in,
    // register port
    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [31:0] reg_rdata_out,
    // event sources
    input  wire        cmd_err_in,
    input  wire        exe_err_in,
    input  wire        qry_err_in,
    input  wire [7:0]  op_event_in,
    input  wire        op_busy_in,
    input  wire        out_empty_in,
    // bus side
    input  wire        serial_poll_in,
    output reg  [7:0]  poll_byte_out,
    output reg         srq_out,
    output reg         hold_bus_out,
    output reg         out_push_out,
    output reg  [7:0]  out_data_out,
    // interrupt
    output reg         irq_out
);

    ////////////////////////////////////////////////////////////////////
    // address decode helper, used for reads and writes
    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state declarations
    reg  [7:0]  sre_r;         // service request enable
    reg  [7:0]  sum_prev_r;    // enabled summaries last cycle
    reg         pon_r;         // power-on event still to post
    reg         opc_pend_r;    // completion command waiting
    reg         opcq_pend_r;   // completion query waiting
    reg  [2:0]  ist_r;         // interrupt status, sticky
    reg  [2:0]  imk_r;         // interrupt mask
    reg  [31:0] rd_nxt;        // read data next value
    wire [7:0]  esr_w;         // standard event register
    wire [7:0]  ese_w;         // standard event enable
    wire [7:0]  opr_w;         // operation event register
    wire [7:0]  ope_w;         // operation event enable
    wire        esb_w;         // standard event summary
    wire        osb_w;         // operation summary
    wire        mav_w;         // message available
    wire [7:0]  sum_w;         // summary bits, bit 6 empty
    wire [7:0]  sum_en_w;      // summaries gated by enables
    wire        mss_w;         // master summary aspect of bit 6
    wire [7:0]  stb_w;         // status byte value
    wire        rise_w;        // an enabled summary rose
    wire [7:0]  std_set_w;     // standard event set pulses
    wire        opc_done_w;    // completion command finishes now
    wire        opcq_done_w;   // completion query finishes now
    wire        cmd_wr_w;      // command register written
    wire        cls_w;         // clear-all command
    wire        esr_rd_w;      // event register query
    wire        opr_rd_w;      // operation register query
    wire [2:0]  iset_w;        // interrupt events this cycle

    ////////////////////////////////////////////////////////////////////
    // write and read decodes
    assign cmd_wr_w = reg_wr_in & hit(reg_addr_in, `SRQ_A_CMD);
    assign cls_w    = cmd_wr_w & reg_wdata_in[`SRQ_C_CLS];
    assign esr_rd_w = reg_rd_in & hit(reg_addr_in, `SRQ_A_ESR);
    assign opr_rd_w = reg_rd_in & hit(reg_addr_in, `SRQ_A_OPR);

    ////////////////////////////////////////////////////////////////////
    // standard event register and its enable
    assign opc_done_w = opc_pend_r & ~op_busy_in; // [RL10]

    // event bit layout of the standard register
    assign std_set_w[`SRQ_EV_PON] = pon_r;       // [RL17]
    assign std_set_w[6]           = 1'b0;
    assign std_set_w[`SRQ_EV_CME] = cmd_err_in;  // [RL17]
    assign std_set_w[`SRQ_EV_EXE] = exe_err_in;  // [RL17]
    assign std_set_w[3]           = 1'b0;
    assign std_set_w[`SRQ_EV_QYE] = qry_err_in;  // [RL17]
    assign std_set_w[1]           = 1'b0;
    assign std_set_w[`SRQ_EV_OPC] = opc_done_w;  // [RL17]

    srq_evreg #(
        .W           (8)
    ) u_std (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .set_in      (std_set_w),
        .clr_in      (esr_rd_w | cls_w),
        .en_wr_in    (reg_wr_in & hit(reg_addr_in, `SRQ_A_ESE)),
        .en_data_in  (reg_wdata_in[7:0]),
        .event_out   (esr_w),
        .enable_out  (ese_w),
        .summary_out (esb_w)
    );

    ////////////////////////////////////////////////////////////////////
    // operation event register and its enable
    srq_evreg #(
        .W           (8)
    ) u_op (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .set_in      (op_event_in),
        .clr_in      (opr_rd_w | cls_w),
        .en_wr_in    (reg_wr_in & hit(reg_addr_in, `SRQ_A_OPE)),
        .en_data_in  (reg_wdata_in[7:0]),
        .event_out   (opr_w),
        .enable_out  (ope_w),
        .summary_out (osb_w)
    );

    ////////////////////////////////////////////////////////////////////
    // status byte assembly; summaries follow their sources
    assign mav_w = ~out_empty_in; // [RL9]

    assign sum_w[`SRQ_SB_OSB] = osb_w;  // [RL16]
    assign sum_w[`SRQ_SB_RQS] = 1'b0;
    assign sum_w[`SRQ_SB_ESB] = esb_w;  // [RL16] [RL15]
    assign sum_w[`SRQ_SB_MAV] = mav_w;  // [RL16]
    assign sum_w[3:0]         = 4'h0;

    // request condition is each summary anded with its enable
    assign sum_en_w = sum_w & sre_r;  // [RL1]
    assign mss_w    = |sum_en_w;      // [RL1] [RL6]

    // bit 6 shows master summary for both poll and query
    assign stb_w = {sum_w[7], mss_w, sum_w[5:0]}; // [RL8]

    // only a 0 to 1 change of an enabled summary asks again
    assign rise_w = |(sum_en_w & ~sum_prev_r); // [RL3] [RL5]

    ////////////////////////////////////////////////////////////////////
    // service request enable register
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            sre_r <= `SRQ_BYTE_ZERO;
        end else if (reg_wr_in & hit(reg_addr_in, `SRQ_A_SRE)) begin
            sre_r <= reg_wdata_in[7:0]; // [RL2] [RL13]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // edge tracking of enabled summaries
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            sum_prev_r <= `SRQ_BYTE_ZERO;
        end else begin
            // a bit must fall before it can raise a new request
            sum_prev_r <= sum_en_w; // [RL5]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request-service flag and request line
    always @(posedge clk_in) begin
        // the request line itself is the request-service aspect of bit 6
        if (sys_rst_in) begin
            srq_out <= 1'b0;
        end else begin
            if (rise_w) begin
                // a new rise wins over a poll in the same cycle
                srq_out <= 1'b1; // [RL3]
            end else if (serial_poll_in) begin
                srq_out <= 1'b0; // [RL4]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // serial poll answer, master summary stays untouched
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            poll_byte_out <= `SRQ_BYTE_ZERO;
        end else if (serial_poll_in) begin
            // controller finds the requester by bit 6
            poll_byte_out <= stb_w; // [RL6] [RL7]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power-on event, posted once after reset
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            pon_r <= 1'b1;
        end else begin
            pon_r <= 1'b0; // [RL17]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // completion command: other commands still accepted meanwhile
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            opc_pend_r <= 1'b0;
        end else if (cmd_wr_w & reg_wdata_in[`SRQ_C_OPC]) begin
            opc_pend_r <= 1'b1; // [RL10]
        end else if (opc_done_w) begin
            opc_pend_r <= 1'b0; // [RL10]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // completion query: hold bus, then queue the reply, no event bit
    assign opcq_done_w = opcq_pend_r & ~op_busy_in; // [RL11]

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            opcq_pend_r  <= 1'b0;
            hold_bus_out <= 1'b0;
            out_push_out <= 1'b0;
            out_data_out <= `SRQ_BYTE_ZERO;
        end else begin
            out_push_out <= opcq_done_w; // [RL11]
            if (opcq_done_w) begin
                out_data_out <= `SRQ_OPC_REPLY; // [RL11]
            end
            // the controller must stay quiet while this is held
            if (cmd_wr_w & reg_wdata_in[`SRQ_C_OPCQ]) begin
                opcq_pend_r  <= 1'b1; // [RL11] [RL12]
                hold_bus_out <= 1'b1; // [RL11]
            end else if (opcq_done_w) begin
                opcq_pend_r  <= 1'b0;
                hold_bus_out <= 1'b0; // [RL11]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt status: write one to clear, set wins
    assign iset_w[`SRQ_I_SRQ]  = rise_w;
    assign iset_w[`SRQ_I_OPCQ] = opcq_done_w;
    assign iset_w[`SRQ_I_POLL] = serial_poll_in;

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            ist_r <= `SRQ_INT_ZERO;
        end else if (reg_wr_in & hit(reg_addr_in, `SRQ_A_IST)) begin
            ist_r <= (ist_r & ~reg_wdata_in[`SRQ_I_W-1:0]) | iset_w;
        end else begin
            ist_r <= ist_r | iset_w;
        end
    end

    // interrupt mask register
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            imk_r <= `SRQ_INT_ZERO;
        end else if (reg_wr_in & hit(reg_addr_in, `SRQ_A_IMK)) begin
            imk_r <= reg_wdata_in[`SRQ_I_W-1:0];
        end
    end

    // level interrupt output
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(ist_r & imk_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero
    always @* begin
        rd_nxt = `SRQ_WORD_ZERO;
        case (reg_addr_in)
            `SRQ_A_STB: rd_nxt[7:0]  = stb_w;     // [RL8]
            `SRQ_A_SRE: rd_nxt[7:0]  = sre_r;     // [RL2]
            `SRQ_A_ESR: rd_nxt[7:0]  = esr_w;     // [RL14]
            `SRQ_A_ESE: rd_nxt[7:0]  = ese_w;
            `SRQ_A_OPR: rd_nxt[7:0]  = opr_w;
            `SRQ_A_OPE: rd_nxt[7:0]  = ope_w;
            `SRQ_A_CMD: rd_nxt[2:0]  = {1'b0, opcq_pend_r, opc_pend_r};
            `SRQ_A_IST: rd_nxt[2:0]  = ist_r;
            `SRQ_A_IMK: rd_nxt[2:0]  = imk_r;
            default:    rd_nxt       = `SRQ_WORD_ZERO;
        endcase
    end

    // read data register, valid the cycle after the strobe
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= `SRQ_WORD_ZERO;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_nxt;
        end else begin
            reg_rdata_out <= `SRQ_WORD_ZERO;
        end
    end

endmodule

`default_nettype wire

//--- dv/srq_status_props.sv
// Purpose: port checker for the status byte and service request block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to srq_status by the statement after the module
`default_nettype none

module srq_status_props (
    // clock and reset
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    // register port
    input wire logic [7:0]  reg_addr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // buffer and operation state
    input wire logic        out_empty_in,
    input wire logic        op_busy_in,
    // bus side
    input wire logic        serial_poll_in,
    input wire logic        srq_out,
    input wire logic        hold_bus_out,
    input wire logic        out_push_out,
    input wire logic [7:0]  out_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////////////
    // reply byte pushed while the bus is let go
    sequence s_reply;
        out_push_out && !hold_bus_out && out_data_out == 8'h31;
    endsequence
    // read data stands one cycle only
    property p_rd_idle;
        !reg_rd_in |=> reg_rdata_out == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    // message-available bit mirrors a nonempty buffer, upper bits zero
    property p_mav;
        reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out[31:8] == 24'h0
            && reg_rdata_out[4] == !$past(out_empty_in);
    endproperty
    a_mav: assert property (p_mav) else $error("status bit 4 wrong");
    // request stands until a poll
    property p_srq_hold;
        srq_out && !serial_poll_in |=> srq_out;
    endproperty
    a_srq_hold: assert property (p_srq_hold) else $error("request lost");
    // request only drops after a poll
    property p_srq_fall;
        $fell(srq_out) |-> $past(serial_poll_in) || $past(sys_rst_in);
    endproperty
    a_srq_fall: assert property (p_srq_fall) else $error("request dropped");
    // pushed byte is the completion reply
    property p_push_data;
        out_push_out |-> s_reply;
    endproperty
    a_push_data: assert property (p_push_data) else $error("bad reply");
    // push is a single pulse
    property p_push_pulse;
        out_push_out |=> !out_push_out;
    endproperty
    a_push_pulse: assert property (p_push_pulse) else $error("long push");
    // bus held while the operation runs
    property p_hold_wait;
        hold_bus_out && op_busy_in |=> hold_bus_out;
    endproperty
    a_hold_wait: assert property (p_hold_wait) else $error("bus freed early");
    // operation done: release and reply on the next edge
    property p_hold_release;
        hold_bus_out && !op_busy_in |=> s_reply;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("no reply");
endmodule

bind srq_status srq_status_props u_srq_status_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .out_empty_in(out_empty_in), .op_busy_in(op_busy_in),
    .serial_poll_in(serial_poll_in), .srq_out(srq_out),
    .hold_bus_out(hold_bus_out), .out_push_out(out_push_out),
    .out_data_out(out_data_out)
);
`default_nettype wire

//--- dv/srq_host_model.sv
// Purpose: bus controller model that polls on request and drains replies
// Assumes: same clock as the block
// Notes:   poll delay set by the bench, replies read after 24 cycles
`default_nettype none

module srq_host_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // block outputs and bench poll delay
    input  wire logic       srq_in,
    input  wire logic       push_in,
    input  wire logic [3:0] dly_in,
    // block inputs
    output var logic        poll_out,
    output var logic        empty_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_r;   // cycles since request seen
    logic [4:0] drain_r;  // cycles until reply is read
    initial poll_out = 1'b0;
    initial empty_out = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // poll after the delay, read out each pushed reply later
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            poll_out <= 1'b0;
            wait_r <= 4'h0;
            drain_r <= 5'h00;
            empty_out <= 1'b1;
        end else begin
            poll_out <= srq_in && wait_r == dly_in;
            if (!srq_in)
                wait_r <= 4'h0;
            else if (wait_r == dly_in)
                wait_r <= 4'h0;
            else
                wait_r <= wait_r + 4'h1;
            if (push_in) begin
                empty_out <= 1'b0;
                drain_r <= 5'h18;
            end else if (drain_r != 5'h00) begin
                drain_r <= drain_r - 5'h01;
                empty_out <= (drain_r == 5'h01);
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/tb.sv
// Purpose: self-checking bench for the status byte block
// Assumes: 25 MHz clock, reset held for ten cycles
// Notes:   reads are queued by the driver and checked by a monitor
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in, sys_rst_in;       // clock and reset
    logic [7:0]  reg_addr_r;               // register address
    logic [31:0] reg_wdata_r;              // write data
    logic        reg_wr_r, reg_rd_r;       // strobes
    logic [2:0]  err_r;                    // command, execution, query
    logic        op_busy_r, rd_d, poll_d;  // busy, monitor delays
    logic [3:0]  poll_dly_r;               // host poll delay
    logic [7:0]  op_ev_r;                  // operation event pulses
    logic [7:0]  lfsr_r;                   // random state
    wire  [31:0] reg_rdata_out;
    wire  [7:0]  poll_byte_out, out_data_out;
    wire         srq_out, hold_bus_out, out_push_out, irq_out;
    wire         serial_poll_in, out_empty_in;
    logic [31:0] exp_q[$];                 // expected read data
    int          n_mismatch, num_checks, k;

    srq_status u_srq_status (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_r),
        .reg_wdata_in(reg_wdata_r), .reg_wr_in(reg_wr_r),
        .reg_rd_in(reg_rd_r), .reg_rdata_out(reg_rdata_out),
        .cmd_err_in(err_r[2]), .exe_err_in(err_r[1]), .qry_err_in(err_r[0]),
        .op_event_in(op_ev_r), .op_busy_in(op_busy_r),
        .out_empty_in(out_empty_in), .serial_poll_in(serial_poll_in),
        .poll_byte_out(poll_byte_out), .srq_out(srq_out),
        .hold_bus_out(hold_bus_out), .out_push_out(out_push_out),
        .out_data_out(out_data_out), .irq_out(irq_out));
    srq_host_model u_srq_host_model (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .srq_in(srq_out),
        .push_in(out_push_out), .dly_in(poll_dly_r),
        .poll_out(serial_poll_in), .empty_out(out_empty_in));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_r <= a;
        reg_wdata_r <= d;
        reg_wr_r <= 1'b1;
        @(posedge clk_in);
        reg_wr_r <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        reg_addr_r <= a;
        reg_rd_r <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        reg_rd_r <= 1'b0;
    endtask
    task automatic pulse(input logic [2:0] m);
        @(posedge clk_in);
        err_r <= m;
        @(posedge clk_in);
        err_r <= 3'h0;
    endtask
    task automatic wait_srq(input logic lvl);
        @(negedge clk_in);
        for (int i = 0; i < 40 && srq_out !== lvl; i++)
            @(negedge clk_in);
        chk("srq_out", {31'h0, srq_out}, {31'h0, lvl});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        repeat (4000) @(posedge clk_in);
        n_mismatch++;
        stop_test();
    end
    // monitor: read data against the oldest note, poll results
    always @(posedge clk_in) begin
        rd_d <= reg_rd_r;
        poll_d <= serial_poll_in;
        if (rd_d)
            chk("reg_rdata_out", reg_rdata_out, exp_q.pop_front());
        if (poll_d) begin
            chk("poll_bit6", {31'h0, poll_byte_out[6]}, 32'h1);
            chk("srq_polled", {31'h0, srq_out}, 32'h0);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst_in = 1'b1;
        {reg_addr_r, reg_wdata_r, reg_wr_r, reg_rd_r} = 42'h0;
        {op_ev_r, err_r, op_busy_r, rd_d, poll_d} = 14'h0000;
        lfsr_r = 8'h49;
        poll_dly_r = 4'h2;
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(8'h08, 32'h80);
        rd(8'h08, 32'h00);
        for (k = 0; k < 3; k++) begin
            pulse(3'h4 >> k);
            rd(8'h08, k == 2 ? 32'h04 : 32'h20 >> k);
        end
        for (k = 0; k < 3; k++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wr(8'(8'h04 + 8'h08 * k), {24'h0, lfsr_r});
            rd(8'(8'h04 + 8'h08 * k), {24'h0, lfsr_r});
        end
        wr(8'h3C, 32'hFF);
        rd(8'h3C, 32'h00);
        wr(8'h0C, 32'h20);
        wr(8'h04, 32'h20);
        wr(8'h20, 32'h01);
        $display("test registers done");
        poll_dly_r <= 4'h2 + {1'b0, lfsr_r[2:0]};
        pulse(3'h4);
        wait_srq(1'b1);
        wait_srq(1'b0);
        rd(8'h00, 32'h60);
        rd(8'h00, 32'h60);
        @(negedge clk_in);
        chk("irq_out", {31'h0, irq_out}, 32'h1);
        pulse(3'h4);
        repeat (12) @(negedge clk_in);
        chk("srq_out", {31'h0, srq_out}, 32'h0);
        rd(8'h08, 32'h20);
        rd(8'h00, 32'h00);
        pulse(3'h4);
        wait_srq(1'b1);
        wait_srq(1'b0);
        rd(8'h1C, 32'h05);
        wr(8'h1C, 32'h07);
        rd(8'h08, 32'h20);
        @(negedge clk_in);
        chk("irq_out", {31'h0, irq_out}, 32'h0);
        $display("test service_request done");
        @(posedge clk_in);
        op_busy_r <= 1'b1;
        wr(8'h18, 32'h01);
        rd(8'h04, 32'h20);
        rd(8'h08, 32'h00);
        op_busy_r <= 1'b0;
        repeat (3) @(posedge clk_in);
        rd(8'h08, 32'h01);
        wr(8'h04, 32'h10);
        op_busy_r <= 1'b1;
        wr(8'h18, 32'h02);
        repeat (4) @(negedge clk_in);
        chk("hold_bus_out", {31'h0, hold_bus_out}, 32'h1);
        @(posedge clk_in);
        op_busy_r <= 1'b0; // only the busy line moves while held
        for (k = 0; k < 20 && out_push_out !== 1'b1; k++)
            @(negedge clk_in);
        chk("out_data_out", {24'h0, out_data_out}, 32'h31);
        rd(8'h08, 32'h00);
        rd(8'h00, 32'h50);
        repeat (40) @(posedge clk_in);
        rd(8'h00, 32'h00);
        @(posedge clk_in);
        op_ev_r <= 8'h01;
        @(posedge clk_in);
        op_ev_r <= 8'h00;
        rd(8'h00, 32'h80);
        rd(8'h10, 32'h01);
        rd(8'h00, 32'h00);
        rd(8'h1C, 32'h07);
        repeat (3) @(posedge clk_in);
        $display("test completion done");
        stop_test();
    end
endmodule
`default_nettype wire
